// ==== shared/enc_consts.svh ====
`ifndef ENC_CONSTS_SVH
`define ENC_CONSTS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define ENC_ADDR_W 8
`define ENC_OFF_IO_CONTROL 8'h00
`define ENC_OFF_GE_COMPARE 8'h04
`define ENC_OFF_LE_COMPARE 8'h08
`define ENC_OFF_IRQ_STATUS 8'h0C
`define ENC_OFF_IRQ_MASK 8'h10
`define ENC_OFF_CAPTURE 8'h14

// ****************************************
// io control field positions
// ****************************************
`define ENC_BIT_CAPTURE_EN 15
`define ENC_BIT_FILTER_EN 14
`define ENC_FDIV_HI 13
`define ENC_FDIV_LO 11
`define ENC_FUNC_HI 10
`define ENC_FUNC_LO 9
`define ENC_BIT_SWAP 8
`define ENC_INV_HI 7
`define ENC_INV_LO 4
`define ENC_LVL_HI 3
`define ENC_LVL_LO 0

// ****************************************
// interrupt status bit positions
// ****************************************
`define ENC_IRQ_CAPTURE 0
`define ENC_IRQ_COMPARE 1

// ****************************************
// reset values and timing
// ****************************************
`define ENC_CTRL_RESET 12'h000
`define ENC_WORD_RESET 16'h0000
`define ENC_IRQ_RESET 2'h0
`define ENC_DIV_RESET 7'h00
`define ENC_FLT_STABLE 2'h2
`define ENC_FLT_ZERO 2'h0

`endif

// ==== shared/enc_pkg.sv ====
package enc_pkg;
    // one data word of the register port
    typedef logic [15:0] word_t;
    // divider code width
    typedef logic [2:0] fdiv_t;
    // compare output function modes
    typedef enum logic [1:0]
    {
        CMP_OFF = 2'h0,
        CMP_GE = 2'h1,
        CMP_LE = 2'h2,
        CMP_WINDOW = 2'h3
    } cmp_mode_e;
endpackage

// ==== shared/filter_if.sv ====
`timescale 1ns/10ps
// conditioned inputs into the filter and cleaned levels back
interface filter_if;
    logic [3:0] raw;
    logic tick;
    logic [3:0] clean;
    modport owner(output raw, output tick, input clean);
    modport filter(input raw, input tick, output clean);
endinterface

// ==== hdl/input_filter.sv ====
`timescale 1ns/10ps
`include "enc_consts.svh"

// ****************************************
// four-channel digital glitch filter
// ****************************************
module input_filter
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // filter side of the carrier
    filter_if.filter flt
);
    // per-channel agreement counters
    logic [1:0] stable_reg [4];
    // filtered levels
    logic [3:0] clean_reg;

    assign flt.clean = clean_reg;

    // a level moves only after three agreeing ticks, so spikes
    // no longer than two divided periods never reach the decoder
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            clean_reg <= 4'h0;
            for (int i = 0; i < 4; i++)
            begin
                stable_reg[i] <= `ENC_FLT_ZERO;
            end
        end
        else if (flt.tick)
        begin
            for (int i = 0; i < 4; i++)
            begin
                // input agrees with output: nothing pending
                if (flt.raw[i] == clean_reg[i])
                begin
                    stable_reg[i] <= `ENC_FLT_ZERO;
                end
                // third disagreeing tick: take the new level
                else if (stable_reg[i] == `ENC_FLT_STABLE)
                begin
                    clean_reg[i] <= flt.raw[i];
                    stable_reg[i] <= `ENC_FLT_ZERO;
                end
                // still counting
                else
                begin
                    stable_reg[i] <= stable_reg[i] + 2'h1;
                end
            end
        end
    end
endmodule

// ==== hdl/encoder_input_conditioning.sv ====
`timescale 1ns/10ps
`include "enc_consts.svh"

// Notes on behaviour
// - capture enable makes index matches capture position
// - filter enable routes all four inputs through filter
// - divider code n divides filter clock by 2^n
// - mode 01 high at/above ge, 10 at/below le
// - mode 11 window; mode 00 leaves pin undriven
// - swap bit exchanges phase a and b
// - four polarity bits invert home, index, b, a
// - read-only levels after polarity, reset undefined

module encoder_input_conditioning
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // register port
    input wire logic [`ENC_ADDR_W-1:0] addr_in,
    input wire logic [15:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rd_data_out,
    // encoder pins
    input wire logic phase_a_pin_in,
    input wire logic phase_b_pin_in,
    input wire logic index_pin_in,
    input wire logic home_pin_in,
    // counter side
    input wire logic [15:0] position_count_in,
    input wire logic index_match_in,
    // conditioned levels to the decoder
    output logic phase_a_level_out,
    output logic phase_b_level_out,
    output logic index_level_out,
    output logic home_level_out,
    // capture result
    output logic capture_pulse_out,
    output logic [15:0] captured_position_out,
    // compare pin
    output logic compare_out_pin_out,
    output logic compare_out_pin_oe_out,
    // interrupt
    output logic irq_out
);

    // ****************************************
    // helper functions
    // ****************************************

    // mask of low divider bits that must be all ones for a tick
    function automatic logic [6:0] div_mask(input enc_pkg::fdiv_t code);
        logic [7:0] one_hot;
        one_hot = 8'h01 << code;
        div_mask = 7'(one_hot - 8'h01);
    endfunction

    // compare decision for a given mode
    function automatic logic cmp_hit(
        input enc_pkg::cmp_mode_e mode,
        input enc_pkg::word_t pos,
        input enc_pkg::word_t ge,
        input enc_pkg::word_t le
    );
        logic at_ge;
        logic at_le;
        at_ge = (pos >= ge);
        at_le = (pos <= le);
        case (mode)
            enc_pkg::CMP_GE: cmp_hit = at_ge;
            enc_pkg::CMP_LE: cmp_hit = at_le;
            enc_pkg::CMP_WINDOW: cmp_hit = at_ge && at_le;
            default: cmp_hit = 1'b0;
        endcase
    endfunction

    // ****************************************
    // registers
    // ****************************************

    // writable upper twelve bits of the io control register
    logic [`ENC_BIT_CAPTURE_EN:`ENC_INV_LO] ctrl_reg;
    // compare thresholds
    enc_pkg::word_t ge_reg;
    enc_pkg::word_t le_reg;
    // sticky interrupt status and its mask
    logic [1:0] irq_status_reg;
    logic [1:0] irq_mask_reg;
    // read data, valid the cycle after a read strobe
    enc_pkg::word_t rd_data_reg;

    // named views of the control fields
    logic capture_on_index_en;
    logic input_filter_en;
    enc_pkg::fdiv_t filter_clock_divider;
    enc_pkg::cmp_mode_e compare_output_function;
    logic swap_phase_inputs;
    logic [3:0] pol_invert;

    assign capture_on_index_en = ctrl_reg[`ENC_BIT_CAPTURE_EN];
    assign input_filter_en = ctrl_reg[`ENC_BIT_FILTER_EN];
    assign filter_clock_divider = ctrl_reg[`ENC_FDIV_HI:`ENC_FDIV_LO];
    assign compare_output_function =
        enc_pkg::cmp_mode_e'(ctrl_reg[`ENC_FUNC_HI:`ENC_FUNC_LO]);
    assign swap_phase_inputs = ctrl_reg[`ENC_BIT_SWAP];
    // order: home, index, phase b, phase a
    assign pol_invert = ctrl_reg[`ENC_INV_HI:`ENC_INV_LO];

    // ****************************************
    // pin synchronisers
    // ****************************************

    // first stage, read only by the second stage
    logic [3:0] pin_meta_reg;
    // second stage, safe for logic
    logic [3:0] pin_sync_reg;

    // pins are asynchronous to clk_in, two flops before any use
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
        end
        else
        begin
            pin_meta_reg <= {home_pin_in, index_pin_in, phase_b_pin_in, phase_a_pin_in};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ****************************************
    // polarity, filter and swap
    // ****************************************

    // levels after polarity control
    logic [3:0] polar_lvl;
    // levels after filter or bypass
    logic [3:0] cond_lvl;
    // filter clock divider count
    logic [6:0] div_cnt_reg;
    // one-cycle filter sample enable
    logic filter_tick_reg;

    assign polar_lvl = pin_sync_reg ^ pol_invert;

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            div_cnt_reg <= `ENC_DIV_RESET;
            filter_tick_reg <= 1'b0;
        end
        else
        begin
            div_cnt_reg <= div_cnt_reg + 7'h01;
            // code zero gives mask zero, a tick every cycle
            filter_tick_reg <= ((div_cnt_reg & div_mask(filter_clock_divider))
                == div_mask(filter_clock_divider));
        end
    end

    // carrier to the filter module
    filter_if flt_bus();

    assign flt_bus.raw = polar_lvl;
    assign flt_bus.tick = filter_tick_reg;

    // filter instance
    input_filter u_filter
    (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .flt(flt_bus.filter)
    );

    assign cond_lvl = input_filter_en ? flt_bus.clean : polar_lvl;

    // registered levels to the decoder
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            phase_a_level_out <= 1'b0;
            phase_b_level_out <= 1'b0;
            index_level_out <= 1'b0;
            home_level_out <= 1'b0;
        end
        // exchange phases ahead of the decoder
        else if (swap_phase_inputs)
        begin
            phase_a_level_out <= cond_lvl[1];
            phase_b_level_out <= cond_lvl[0];
            index_level_out <= cond_lvl[2];
            home_level_out <= cond_lvl[3];
        end
        // straight through
        else
        begin
            phase_a_level_out <= cond_lvl[0];
            phase_b_level_out <= cond_lvl[1];
            index_level_out <= cond_lvl[2];
            home_level_out <= cond_lvl[3];
        end
    end

    // ****************************************
    // index capture
    // ****************************************

    // capture event of this cycle
    logic capture_event;

    assign capture_event = index_match_in && capture_on_index_en;

    // latch the count and pulse once per event
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            capture_pulse_out <= 1'b0;
            captured_position_out <= `ENC_WORD_RESET;
        end
        else
        begin
            capture_pulse_out <= capture_event;
            // take the count on the event
            if (capture_event)
            begin
                captured_position_out <= position_count_in;
            end
        end
    end

    // ****************************************
    // compare output
    // ****************************************

    // combinational compare result, and its rise against the registered pin
    logic cmp_level;
    logic cmp_rise;

    assign cmp_level = cmp_hit(compare_output_function, position_count_in, ge_reg, le_reg);
    assign cmp_rise = cmp_level && !compare_out_pin_out;

    // pin value and enable
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            compare_out_pin_out <= 1'b0;
            compare_out_pin_oe_out <= 1'b0;
        end
        else
        begin
            compare_out_pin_out <= cmp_level;
            compare_out_pin_oe_out <= (compare_output_function != enc_pkg::CMP_OFF);
        end
    end

    // ****************************************
    // register writes
    // ****************************************

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            ctrl_reg <= `ENC_CTRL_RESET;
            ge_reg <= `ENC_WORD_RESET;
            le_reg <= `ENC_WORD_RESET;
            irq_mask_reg <= `ENC_IRQ_RESET;
        end
        else if (wr_in)
        begin
            // address decode, unmapped writes dropped
            if (addr_in == `ENC_OFF_IO_CONTROL)
            begin
                // low nibble is read-only status
                ctrl_reg <= wr_data_in[`ENC_BIT_CAPTURE_EN:`ENC_INV_LO];
            end
            else if (addr_in == `ENC_OFF_GE_COMPARE)
            begin
                ge_reg <= wr_data_in;
            end
            else if (addr_in == `ENC_OFF_LE_COMPARE)
            begin
                le_reg <= wr_data_in;
            end
            else if (addr_in == `ENC_OFF_IRQ_MASK)
            begin
                irq_mask_reg <= wr_data_in[1:0];
            end
        end
    end

    // ****************************************
    // interrupt status
    // ****************************************

    // events of this cycle in status layout
    logic [1:0] irq_events;
    logic status_read;

    assign irq_events = {cmp_rise, capture_event};
    assign status_read = rd_in && (addr_in == `ENC_OFF_IRQ_STATUS);

    // read clears, but a same-cycle event still lands
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            irq_status_reg <= `ENC_IRQ_RESET;
        end
        else if (status_read)
        begin
            irq_status_reg <= irq_events;
        end
        else
        begin
            irq_status_reg <= irq_status_reg | irq_events;
        end
    end

    // level interrupt, one cycle behind the status
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            irq_out <= 1'b0;
        end
        else
        begin
            irq_out <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // ****************************************
    // register reads
    // ****************************************

    // live levels sit in the low nibble of io control
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            rd_data_reg <= `ENC_WORD_RESET;
        end
        else if (rd_in)
        begin
            if (addr_in == `ENC_OFF_IO_CONTROL)
            begin
                rd_data_reg <= {ctrl_reg, cond_lvl};
            end
            else if (addr_in == `ENC_OFF_GE_COMPARE)
            begin
                rd_data_reg <= ge_reg;
            end
            else if (addr_in == `ENC_OFF_LE_COMPARE)
            begin
                rd_data_reg <= le_reg;
            end
            else if (addr_in == `ENC_OFF_IRQ_STATUS)
            begin
                rd_data_reg <= {14'h0000, irq_status_reg};
            end
            else if (addr_in == `ENC_OFF_IRQ_MASK)
            begin
                rd_data_reg <= {14'h0000, irq_mask_reg};
            end
            else if (addr_in == `ENC_OFF_CAPTURE)
            begin
                rd_data_reg <= captured_position_out;
            end
            // unmapped reads answer zero
            else
            begin
                rd_data_reg <= `ENC_WORD_RESET;
            end
        end
        // data stand only in the cycle after the strobe
        else
        begin
            rd_data_reg <= `ENC_WORD_RESET;
        end
    end

    assign rd_data_out = rd_data_reg;

endmodule

// ==== verif/enc_cond_assertions.sv ====
`timescale 1ns/10ps
`include "enc_consts.svh"
module enc_cond_assertions
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // register port
    input wire logic [`ENC_ADDR_W-1:0] addr_in,
    input wire logic [15:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] rd_data_out,
    // pins and counter side
    input wire logic phase_a_pin_in,
    input wire logic phase_b_pin_in,
    input wire logic [15:0] position_count_in,
    input wire logic index_match_in,
    // results
    input wire logic phase_a_level_out,
    input wire logic capture_pulse_out,
    input wire logic [15:0] captured_position_out,
    input wire logic compare_out_pin_out,
    input wire logic compare_out_pin_oe_out,
    input wire logic irq_out
);
    logic [15:0] ctl_sh; // mirror of io control
    logic [15:0] ge_sh; // mirror of lower threshold
    logic [15:0] le_sh; // mirror of upper threshold
    logic [1:0] msk_sh; // mirror of irq mask
    logic ge_hit; // count at or above ge
    logic le_hit; // count at or below le
    assign ge_hit = position_count_in >= ge_sh;
    assign le_hit = position_count_in <= le_sh;
    // mirror software writes; unmapped ones are dropped like the design does
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            ctl_sh <= 16'h0000;
            ge_sh <= 16'h0000;
            le_sh <= 16'h0000;
            msk_sh <= 2'h0;
        end
        else if (wr_in)
        begin
            case (addr_in)
                `ENC_OFF_IO_CONTROL: ctl_sh <= wr_data_in;
                `ENC_OFF_GE_COMPARE: ge_sh <= wr_data_in;
                `ENC_OFF_LE_COMPARE: le_sh <= wr_data_in;
                `ENC_OFF_IRQ_MASK: msk_sh <= wr_data_in[1:0];
                default: ;
            endcase
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // ****************************************
    // checks
    // ****************************************
    sequence s_match_on;
        index_match_in && ctl_sh[15];
    endsequence
    // bypass path needs a quiet config for the sync flops to flush
    sequence s_quiet_bypass;
        ($stable(ctl_sh) && !ctl_sh[14])[*4];
    endsequence
    a_capture_taken: assert property (
        s_match_on |=> capture_pulse_out && captured_position_out == $past(position_count_in))
        else $error("capture missing or wrong value");
    a_capture_blocked: assert property (
        index_match_in && !ctl_sh[15] |=> !capture_pulse_out)
        else $error("capture while disabled");
    a_ge_mode: assert property (
        ctl_sh[10:9] == enc_pkg::CMP_GE |=> compare_out_pin_out == $past(ge_hit))
        else $error("ge compare wrong");
    a_le_mode: assert property (
        ctl_sh[10:9] == enc_pkg::CMP_LE |=> compare_out_pin_out == $past(le_hit))
        else $error("le compare wrong");
    a_window_mode: assert property (
        ctl_sh[10:9] == enc_pkg::CMP_WINDOW
        |=> compare_out_pin_out == ($past(ge_hit) && $past(le_hit)))
        else $error("window compare wrong");
    a_off_released: assert property (
        ctl_sh[10:9] == enc_pkg::CMP_OFF |=> !compare_out_pin_oe_out && !compare_out_pin_out)
        else $error("compare pin driven while off");
    a_phase_path: assert property (
        s_quiet_bypass |-> phase_a_level_out == (ctl_sh[8] ? $past(phase_b_pin_in, 3) ^ ctl_sh[5]
        : $past(phase_a_pin_in, 3) ^ ctl_sh[4]))
        else $error("phase a level wrong");
    a_irq_capture: assert property (
        capture_pulse_out && msk_sh[0] |=> irq_out)
        else $error("irq missing after capture");
    a_ctrl_readback: assert property (
        rd_in && addr_in == `ENC_OFF_IO_CONTROL |=> rd_data_out[15:4] == ctl_sh[15:4])
        else $error("control readback wrong");
endmodule
bind encoder_input_conditioning enc_cond_assertions i_chk (.clk_in, .rst_b_in, .addr_in,
    .wr_data_in, .wr_in, .rd_in, .rd_data_out, .phase_a_pin_in, .phase_b_pin_in,
    .position_count_in, .index_match_in, .phase_a_level_out, .capture_pulse_out,
    .captured_position_out, .compare_out_pin_out, .compare_out_pin_oe_out, .irq_out);

// ==== verif/enc_model.sv ====
`timescale 1ns/10ps
// ****************************************
// incremental encoder with index and home
// ****************************************
module enc_model
(
    // clock and controls from the bench
    input wire logic clk_in,
    input wire logic step_in,
    input wire logic home_in,
    // encoder lines
    output logic phase_a_out,
    output logic phase_b_out,
    output logic index_out,
    output logic home_out
);
    logic [1:0] st_reg = 2'h0; // quadrature state
    // one quarter step per pulse; gaps set the speed
    always @(posedge clk_in)
    begin
        if (step_in)
        begin
            st_reg <= st_reg + 2'h1;
        end
    end
    // gray order so only one line moves per step
    assign phase_a_out = st_reg[1] ^ st_reg[0];
    assign phase_b_out = st_reg[1];
    // index marks state zero, home follows the switch
    assign index_out = st_reg == 2'h0;
    assign home_out = home_in;
endmodule

// ==== verif/encoder_input_conditioning_bench.sv ====
`timescale 1ns/10ps
`include "enc_consts.svh"
module encoder_input_conditioning_bench;
    logic clk_in;
    logic rst_b_in;
    logic [`ENC_ADDR_W-1:0] addr_in;
    logic [15:0] wr_data_in, rd_data_out, position_count_in, captured_position_out, v;
    logic wr_in, rd_in, index_match_in, step, home_sw, p, e;
    logic phase_a_pin_in, phase_b_pin_in, index_pin_in, home_pin_in;
    logic phase_a_level_out, phase_b_level_out, index_level_out, home_level_out;
    logic capture_pulse_out, compare_out_pin_out, compare_out_pin_oe_out, irq_out;
    logic [1:0] prev;
    logic [15:0] tbl [4] = '{16'h00FF, 16'h0100, 16'h0200, 16'h0201};
    int err_total, num_checks, n, lo, hi;
    // free-running 100 MHz clock
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    enc_model i_enc (.clk_in, .step_in(step), .home_in(home_sw), .phase_a_out(phase_a_pin_in),
        .phase_b_out(phase_b_pin_in), .index_out(index_pin_in), .home_out(home_pin_in));
    encoder_input_conditioning i_dut (.clk_in, .rst_b_in, .addr_in, .wr_data_in, .wr_in,
        .rd_in, .rd_data_out, .phase_a_pin_in, .phase_b_pin_in, .index_pin_in, .home_pin_in,
        .position_count_in, .index_match_in, .phase_a_level_out, .phase_b_level_out,
        .index_level_out, .home_level_out, .capture_pulse_out, .captured_position_out,
        .compare_out_pin_out, .compare_out_pin_oe_out, .irq_out);
    // compare and count; x never matches
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string w);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, w, got, exp);
        end
    endtask
    // one-cycle write; idle cycle after so strobes never retoggle in one step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        @(posedge clk_in);
    endtask
    // read data is only valid in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] m,
        input string w);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(negedge clk_in);
        chk(rd_data_out & m, exp, w);
        @(posedge clk_in);
    endtask
    // index match pulse, pulse output seen mid next cycle
    task automatic mt();
        index_match_in <= 1'b1;
        @(posedge clk_in);
        index_match_in <= 1'b0;
        @(negedge clk_in);
        p = capture_pulse_out;
        @(posedge clk_in);
    endtask
    // verdict in one place
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // hang guard, well beyond the few thousand cycles needed
    initial
    begin
        #200000;
        err_total++;
        $display("MISMATCH t=%0t watchdog", $time);
        tally_and_finish();
    end
    initial
    begin
        {rst_b_in, addr_in, wr_data_in, wr_in, rd_in, index_match_in, step} = '0;
        position_count_in = 16'h0000;
        home_sw = 1'b1;
        err_total = 0;
        num_checks = 0;
        repeat (4) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(posedge clk_in);
        rdc(`ENC_OFF_IO_CONTROL, 16'h0000, 16'hFFF0, "ctrl reset");
        rdc(8'h1C, 16'h0000, 16'hFFFF, "unmapped read");
        wr(`ENC_OFF_IO_CONTROL, 16'h000F);
        rdc(`ENC_OFF_IO_CONTROL, 16'h000C, 16'hFFFF, "level bits read only");
        $display("test reset done");
        // every polarity combination against fixed pins
        for (int i = 0; i < 16; i++)
        begin
            wr(`ENC_OFF_IO_CONTROL, 16'(i << 4));
            repeat (4) @(posedge clk_in);
            rdc(`ENC_OFF_IO_CONTROL, 16'((i << 4) | (4'hC ^ i)), 16'hFFFF, "polarity");
            chk(16'({home_level_out, index_level_out, phase_b_level_out, phase_a_level_out}),
                16'(4'hC ^ i), "levels");
        end
        $display("test polarity done");
        step <= 1'b1;
        @(posedge clk_in);
        step <= 1'b0;
        wr(`ENC_OFF_IO_CONTROL, 16'h0100);
        repeat (5) @(posedge clk_in);
        chk(16'({phase_a_level_out, phase_b_level_out}), 16'h0001, "swapped");
        rdc(`ENC_OFF_IO_CONTROL, 16'h0109, 16'hFFFF, "status before swap");
        $display("test swap done");
        // bypass first, then every divider code; delay must scale with 2^code
        for (int c = -1; c < 8; c++)
        begin
            wr(`ENC_OFF_IO_CONTROL, c < 0 ? 16'h0000 : 16'(16'h4000 | (c << 11)));
            repeat (10 + 5 * (1 << (c < 0 ? 0 : c))) @(posedge clk_in);
            prev = {phase_a_level_out, phase_b_level_out};
            step <= 1'b1;
            @(posedge clk_in);
            step <= 1'b0;
            n = 0;
            do
            begin
                @(negedge clk_in);
                n++;
            end
            while ({phase_a_level_out, phase_b_level_out} === prev && n < 2000);
            @(posedge clk_in);
            // two sync flops, then three ticks whose first falls anywhere in one period
            lo = c < 0 ? 1 : 2 * (1 << c) + 5;
            hi = c < 0 ? 4 : 3 * (1 << c) + 4;
            chk(16'(n >= lo && n <= hi), 16'h0001, "filter delay");
        end
        $display("test filter done");
        wr(`ENC_OFF_IO_CONTROL, 16'h0000);
        wr(`ENC_OFF_IRQ_MASK, 16'h0001);
        position_count_in <= 16'h1234;
        mt();
        chk(16'(p), 16'h0000, "capture while off");
        wr(`ENC_OFF_IO_CONTROL, 16'h8000);
        mt();
        chk(16'(p), 16'h0001, "capture pulse");
        chk(captured_position_out, 16'h1234, "captured value");
        @(negedge clk_in);
        chk(16'(irq_out), 16'h0001, "irq raised");
        @(posedge clk_in);
        rdc(`ENC_OFF_IRQ_STATUS, 16'h0001, 16'hFFFF, "status sticky");
        @(negedge clk_in);
        chk(16'(irq_out), 16'h0000, "irq cleared by read");
        @(posedge clk_in);
        wr(`ENC_OFF_IRQ_MASK, 16'h0000);
        position_count_in <= 16'hBEEF;
        mt();
        mt();
        chk(16'(p), 16'h0001, "back to back capture");
        @(negedge clk_in);
        chk(16'(irq_out), 16'h0000, "irq masked");
        @(posedge clk_in);
        rdc(`ENC_OFF_CAPTURE, 16'hBEEF, 16'hFFFF, "capture register");
        rdc(`ENC_OFF_IRQ_STATUS, 16'h0001, 16'h0001, "masked status");
        $display("test capture done");
        wr(`ENC_OFF_GE_COMPARE, 16'h0100);
        wr(`ENC_OFF_LE_COMPARE, 16'h0200);
        // each mode against counts on both sides of both thresholds
        for (int m = 0; m < 4; m++)
        begin
            wr(`ENC_OFF_IO_CONTROL, 16'(m << 9));
            for (int k = 0; k < 4; k++)
            begin
                position_count_in <= tbl[k];
                repeat (2) @(posedge clk_in);
                @(negedge clk_in);
                e = m == 1 ? tbl[k] >= 16'h0100 : m == 2 ? tbl[k] <= 16'h0200 :
                    m == 3 ? (tbl[k] >= 16'h0100 && tbl[k] <= 16'h0200) : 1'b0;
                chk(16'({compare_out_pin_oe_out, compare_out_pin_out}), 16'({m != 0, e}),
                    "compare pin");
                @(posedge clk_in);
            end
        end
        // rising compare result leaves its sticky status bit behind
        rdc(`ENC_OFF_IRQ_STATUS, 16'h0002, 16'h0002, "compare status");
        $display("test compare done");
        tally_and_finish();
    end
endmodule
